// ==== common/acrz_pkg.sv ====
// Constants shared by the converter control register block.
package acrz_pkg;

  localparam int unsigned ADDR_W_DEF = 12;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned STRB_W     = 4;

  localparam logic [11:0] CCZ_OFFSET = 12'hf70;
  localparam logic [7:0]  CCZ_RESET  = 8'h00;

  localparam int unsigned START_BIT = 7;
  localparam int unsigned RSV_HI    = 6;
  localparam int unsigned REF_BIT   = 5;
  localparam int unsigned PWR_BIT   = 4;
  localparam int unsigned RSV_LO    = 3;
  localparam int unsigned SEL_LSB   = 0;
  localparam int unsigned SEL_W     = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : acrz_pkg

// ==== common/acrz_reg_if.sv ====
// Register access strobes between the bus slave and the register logic.
`timescale 1ns/1ps
`default_nettype none
interface acrz_reg_if #(
  parameter int unsigned ADDR_W = 12
);
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_hit;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_hit;

  modport bus (
    output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input  wr_hit, rd_data, rd_hit
  );
  modport regs (
    input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_hit, rd_data, rd_hit
  );
endinterface : acrz_reg_if
`default_nettype wire

// ==== logic/acrz_axil_slave.sv ====
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/1ps
`default_nettype none
module acrz_axil_slave #(
  parameter int unsigned ADDR_W = acrz_pkg::ADDR_W_DEF
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  acrz_reg_if.bus                regs
);
  import acrz_pkg::*;

  typedef struct packed {
    logic              aw_full;
    logic [ADDR_W-1:0] awaddr;
    logic              w_full;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } acrz_slv_state_t;

  acrz_slv_state_t s_ff;
  acrz_slv_state_t nxt_s;

  assign awready      = !s_ff.aw_full;
  assign wready       = !s_ff.w_full;
  assign arready      = !s_ff.rvalid;
  assign bvalid       = s_ff.bvalid;
  assign bresp        = s_ff.bresp;
  assign rvalid       = s_ff.rvalid;
  assign rdata        = s_ff.rdata;
  assign rresp        = s_ff.rresp;
  assign regs.wr_en   = s_ff.aw_full && s_ff.w_full && !s_ff.bvalid;
  assign regs.wr_addr = s_ff.awaddr;
  assign regs.wr_data = s_ff.wdata;
  assign regs.wr_strb = s_ff.wstrb;
  assign regs.rd_en   = arvalid && !s_ff.rvalid;
  assign regs.rd_addr = araddr;

  // Address and data are held independently, so either may arrive first.
  always_comb begin
    nxt_s = s_ff;
    if (awvalid && awready) begin
      nxt_s.aw_full = 1'b1;
      nxt_s.awaddr  = awaddr;
    end
    if (wvalid && wready) begin
      nxt_s.w_full = 1'b1;
      nxt_s.wdata  = wdata;
      nxt_s.wstrb  = wstrb;
    end
    if (s_ff.bvalid && bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (regs.wr_en) begin
      nxt_s.aw_full = 1'b0;
      nxt_s.w_full  = 1'b0;
      nxt_s.bvalid  = 1'b1;
      nxt_s.bresp   = regs.wr_hit ? RESP_OKAY : RESP_DECERR;
    end
    if (regs.rd_en) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata  = regs.rd_data;
      nxt_s.rresp  = regs.rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_ff.rvalid && rready) begin
      nxt_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule : acrz_axil_slave
`default_nettype wire

// ==== logic/acrz_top.sv ====
// Converter control register zero with its conversion start and busy logic.
// Summary of operation
// - Writing one to start with power enable one launches a conversion when idle; start reads one while busy.
// - Writing zero to start does nothing; start reads zero when idle.
// - Reference bit one enables internal reference; zero selects external one.
// - Power enable bit zero powers converter down; one enables conversions.
// - Three-bit select field picks analog input zero through seven.
`timescale 1ns/1ps
`default_nettype none
module acrz_top #(
  parameter int unsigned ADDR_W = acrz_pkg::ADDR_W_DEF
) (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic                           awvalid,
  output logic                                awready,
  input  wire logic [ADDR_W-1:0]              awaddr,
  input  wire logic [2:0]                     awprot,
  input  wire logic                           wvalid,
  output logic                                wready,
  input  wire logic [acrz_pkg::DATA_W-1:0]    wdata,
  input  wire logic [acrz_pkg::STRB_W-1:0]    wstrb,
  output logic                                bvalid,
  input  wire logic                           bready,
  output logic [1:0]                          bresp,
  input  wire logic                           arvalid,
  output logic                                arready,
  input  wire logic [ADDR_W-1:0]              araddr,
  input  wire logic [2:0]                     arprot,
  output logic                                rvalid,
  input  wire logic                           rready,
  output logic [acrz_pkg::DATA_W-1:0]         rdata,
  output logic [1:0]                          rresp,
  input  wire logic                           conversion_done,
  output logic                                conversion_start,
  output logic                                conversion_busy,
  output logic                                internal_reference_enable,
  output logic                                converter_power_enable,
  output logic [acrz_pkg::SEL_W-1:0]          analog_input_select
);
  import acrz_pkg::*;

  if (ADDR_W < 12 || ADDR_W > 32) begin : g_addr_check
    $error("ADDR_W must lie between 12 and 32 to reach the register.");
  end

  localparam logic [ADDR_W-1:0] REG_ADDR = ADDR_W'(CCZ_OFFSET);

  typedef struct packed {
    logic             busy;
    logic             rsv_hi;
    logic             ref_en;
    logic             pwr_en;
    logic             rsv_lo;
    logic [SEL_W-1:0] sel;
    logic             start_pulse;
    logic             done_s1;
    logic             done_s2;
    logic             done_s3;
    logic             done_lvl;
  } acrz_state_t;

  acrz_state_t s_ff;
  acrz_state_t nxt_s;

  acrz_reg_if #(.ADDR_W(ADDR_W)) regs ();

  acrz_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .regs    (regs.bus)
  );

  logic       wr_reg;
  logic       done_evt;
  logic       start_ok;
  logic [7:0] reg_value;

  assign regs.wr_hit = regs.wr_addr[ADDR_W-1:2] == REG_ADDR[ADDR_W-1:2];
  assign regs.rd_hit = regs.rd_addr[ADDR_W-1:2] == REG_ADDR[ADDR_W-1:2];
  assign wr_reg      = regs.wr_en && regs.wr_hit && regs.wr_strb[0];

  // The busy flag sits in the start position of the read value.
  assign reg_value = {s_ff.busy, s_ff.rsv_hi, s_ff.ref_en, s_ff.pwr_en,
                      s_ff.rsv_lo, s_ff.sel};
  assign regs.rd_data = regs.rd_hit ? {24'h000000, reg_value} : 32'h00000000;

  // The finish level counts only once the second and third stages agree.
  assign done_evt = s_ff.done_s2 && s_ff.done_s3 && !s_ff.done_lvl;

  // A start needs an idle converter and power left on by the same write.
  assign start_ok = wr_reg && regs.wr_data[START_BIT] && !s_ff.busy &&
                    regs.wr_data[PWR_BIT];

  always_comb begin
    nxt_s             = s_ff;
    nxt_s.start_pulse = 1'b0;
    nxt_s.done_s1     = conversion_done;
    nxt_s.done_s2     = s_ff.done_s1;
    nxt_s.done_s3     = s_ff.done_s2;
    if (s_ff.done_s2 == s_ff.done_s3) begin
      nxt_s.done_lvl = s_ff.done_s3;
    end
    if (done_evt) begin
      nxt_s.busy = 1'b0;
    end
    if (wr_reg) begin
      nxt_s.rsv_hi = regs.wr_data[RSV_HI];
      nxt_s.ref_en = regs.wr_data[REF_BIT];
      nxt_s.pwr_en = regs.wr_data[PWR_BIT];
      nxt_s.rsv_lo = regs.wr_data[RSV_LO];
      nxt_s.sel    = regs.wr_data[SEL_LSB +: SEL_W];
      if (!regs.wr_data[PWR_BIT]) begin
        nxt_s.busy = 1'b0;
      end
    end
    // A start in the cycle that a finish clears busy is refused, as start_ok still sees busy.
    if (start_ok) begin
      nxt_s.busy        = 1'b1;
      nxt_s.start_pulse = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign conversion_start          = s_ff.start_pulse;
  assign conversion_busy           = s_ff.busy;
  assign internal_reference_enable = s_ff.ref_en;
  assign converter_power_enable    = s_ff.pwr_en;
  assign analog_input_select       = s_ff.sel;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_start_sets_busy: assert property (
    start_ok |=> conversion_busy && conversion_start
      ##1 !conversion_start)
    else $error("Accepted start did not raise busy with a single pulse.");

  a_busy_reads_one: assert property (
    regs.rd_en && regs.rd_hit && conversion_busy
      |=> rvalid && rdata[START_BIT])
    else $error("Read during a conversion did not return start as one.");

  a_zero_write_noop: assert property (
    wr_reg && !regs.wr_data[START_BIT] && !conversion_busy
      |=> !conversion_busy && !conversion_start)
    else $error("Writing zero to start changed the converter state.");

  a_idle_reads_zero: assert property (
    regs.rd_en && regs.rd_hit && !conversion_busy && !start_ok
      |=> rvalid && !rdata[START_BIT])
    else $error("Idle read returned start as one.");

  a_reference_follows: assert property (
    wr_reg |=> internal_reference_enable == $past(regs.wr_data[REF_BIT]))
    else $error("Reference enable does not follow the written bit.");

  a_power_follows: assert property (
    wr_reg && !regs.wr_data[PWR_BIT]
      |=> !converter_power_enable && !conversion_busy)
    else $error("Power down did not disable the converter and stop busy.");

  a_select_follows: assert property (
    wr_reg |=> analog_input_select ==
      $past(regs.wr_data[SEL_LSB +: SEL_W]))
    else $error("Input select does not follow the written field.");

  a_done_clears: assert property (
    conversion_busy && done_evt && !start_ok |=> !conversion_busy)
    else $error("Finished conversion left busy set.");

  a_busy_ignores: assert property (
    conversion_busy && wr_reg && regs.wr_data[START_BIT]
      |=> !conversion_start)
    else $error("Start while busy launched another conversion.");

  a_done_latency: assert property (
    conversion_busy && !done_evt ##1 done_evt
      |=> !conversion_busy || conversion_start)
    else $error("Busy survived a synchronised finish.");

  // These checks tie the start, reference, power and select fields to their outputs and read values.
  a_start_idle_power: assert property (
    wr_reg && regs.wr_data[START_BIT] && regs.wr_data[PWR_BIT] &&
      !conversion_busy |=> conversion_start && conversion_busy)
    else $error("Start to an idle powered converter was not taken.");

  a_busy_rise_start: assert property (
    !conversion_busy ##1 conversion_busy
      |-> conversion_start)
    else $error("Busy rose without a conversion start pulse.");

  a_start_one_pulse: assert property (
    conversion_start
      |=> !conversion_start)
    else $error("Conversion start stood longer than one cycle.");

  a_busy_held_quiet: assert property (
    conversion_busy && !done_evt && !wr_reg
      |=> conversion_busy)
    else $error("Busy fell with no finish and no register write.");

  a_read_start_bit: assert property (
    regs.rd_en && regs.rd_hit
      |=> rdata[START_BIT] == $past(conversion_busy))
    else $error("Start bit read back differs from the busy state.");

  a_start_needs_write: assert property (
    !(wr_reg && regs.wr_data[START_BIT])
      |=> !conversion_start)
    else $error("Conversion started without a write of one to start.");

  a_reference_holds: assert property (
    !wr_reg
      |=> $stable(internal_reference_enable))
    else $error("Reference enable changed without a register write.");

  a_read_reference: assert property (
    regs.rd_en && regs.rd_hit
      |=> rdata[REF_BIT] == $past(internal_reference_enable))
    else $error("Reference bit read back differs from its output.");

  a_power_holds: assert property (
    !wr_reg
      |=> $stable(converter_power_enable))
    else $error("Power enable changed without a register write.");

  a_power_gates_start: assert property (
    wr_reg && regs.wr_data[START_BIT] && !regs.wr_data[PWR_BIT]
      |=> !conversion_start && !conversion_busy)
    else $error("Start with power off launched a conversion.");

  a_busy_needs_power: assert property (
    conversion_busy
      |-> converter_power_enable)
    else $error("Converter busy while powered down.");

  a_read_power: assert property (
    regs.rd_en && regs.rd_hit
      |=> rdata[PWR_BIT] == $past(converter_power_enable))
    else $error("Power bit read back differs from its output.");

  a_select_holds: assert property (
    !wr_reg
      |=> $stable(analog_input_select))
    else $error("Input select changed without a register write.");

  a_read_select: assert property (
    regs.rd_en && regs.rd_hit
      |=> rdata[SEL_LSB +: SEL_W] == $past(analog_input_select))
    else $error("Select field read back differs from its output.");

  a_busy_fall_cause: assert property (
    conversion_busy ##1 !conversion_busy
      |-> $past(done_evt) || !converter_power_enable)
    else $error("Busy cleared with no finish and no power down.");

  a_busy_write_keeps: assert property (
    conversion_busy && wr_reg && regs.wr_data[PWR_BIT] && !done_evt
      |=> conversion_busy)
    else $error("Register write with power on cleared busy.");

  a_stray_done_idle: assert property (
    !conversion_busy && done_evt && !(wr_reg && regs.wr_data[START_BIT])
      |=> !conversion_busy)
    else $error("Finish while idle set the busy flag.");

  a_start_needs_idle: assert property (
    conversion_start
      |-> !$past(conversion_busy))
    else $error("Conversion start issued while already busy.");

  a_finish_sync_delay: assert property (
    conversion_busy && !conversion_done ##1 !conversion_done
      ##1 conversion_done [*2]
      |-> ##3 (!conversion_busy || conversion_start))
    else $error("Busy did not clear three cycles after a finish.");

  c_start: cover property (start_ok ##1 conversion_start);
  c_finish: cover property (conversion_busy ##[1:50] !conversion_busy);
  c_busy_read: cover property (regs.rd_en && regs.rd_hit && conversion_busy);
  c_abort: cover property (conversion_busy && wr_reg &&
                           !regs.wr_data[PWR_BIT]);
  c_power_block: cover property (wr_reg && regs.wr_data[START_BIT] &&
                                 !regs.wr_data[PWR_BIT]);

endmodule : acrz_top
`default_nettype wire

// ==== testbench/acrz_core_model.sv ====
// Behavioural model of the analog converter core behind the control register.
`timescale 1ns/1ps
`default_nettype none
module acrz_core_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       start,
  input  wire logic       pwr,
  input  wire logic [7:0] dly,
  output logic            done
);
  logic [7:0] cnt_ff;
  logic [2:0] hold_ff;
  // A powered-down core loses its conversion and never signals a finish.
  always_ff @(posedge aclk) begin
    if (!aresetn || !pwr) begin
      cnt_ff  <= 8'h00;
      hold_ff <= 3'h0;
    end else if (start) begin
      cnt_ff <= dly;
    end else if (cnt_ff == 8'h01) begin
      cnt_ff  <= 8'h00;
      hold_ff <= 3'h4;
    end else begin
      if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
      if (hold_ff != 3'h0) hold_ff <= hold_ff - 3'h1;
    end
  end
  // Done stays high four cycles so the synchroniser sees it, then falls.
  assign done = (hold_ff != 3'h0);
endmodule : acrz_core_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the converter control register block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import acrz_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [2:0]  awprot, arprot, analog_input_select;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        conversion_done, conversion_start, conversion_busy;
  logic        internal_reference_enable, converter_power_enable;
  logic [7:0]  dly, n_start, e;
  int          n_mismatch, checked;

  acrz_top u_acrz_top (.*);
  acrz_core_model u_acrz_core_model (.aclk(aclk), .aresetn(aresetn),
    .start(conversion_start), .pwr(converter_power_enable), .dly(dly),
    .done(conversion_done));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) if (conversion_start) n_start <= n_start + 8'h01;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic got;
    @(posedge aclk);
    got = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        bready <= 1'b0;
        chk(bresp, er);
      end
    end
  endtask : wr

  task automatic rdr(input logic [11:0] a, input logic [1:0] er);
    logic got;
    @(posedge aclk);
    got = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        rd = rdata;
        rready <= 1'b0;
        chk(rresp, er);
      end
    end
  endtask : rdr

  task automatic wait_idle;
    int i;
    i = 0;
    rd = 32'h80;
    while (rd[7] && i < 60) begin
      rdr(CCZ_OFFSET, RESP_OKAY);
      i++;
    end
  endtask : wait_idle

  task automatic give_verdict;
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, awprot, arprot} = 30'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    dly = 8'h14;
    n_start = 8'h00;
    n_mismatch = 0;
    checked = 0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(CCZ_OFFSET, RESP_OKAY);
    chk(rd, {24'h0, CCZ_RESET});
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      e = {2'b00, i[0], i[1], 1'b0, i[2:0]};
      wr(CCZ_OFFSET, {24'h0, e}, 4'h1, RESP_OKAY);
      chk({26'h0, internal_reference_enable, converter_power_enable, 1'b0,
           analog_input_select}, {24'h0, e});
      rdr(CCZ_OFFSET, RESP_OKAY);
      chk(rd, {24'h0, e});
    end
    chk(n_start, 8'h00);
    $display("test fields done");
    wr(CCZ_OFFSET, 32'h91, 4'h1, RESP_OKAY);
    chk(conversion_busy, 1'b1);
    wr(CCZ_OFFSET, 32'h93, 4'h1, RESP_OKAY);
    rdr(CCZ_OFFSET, RESP_OKAY);
    chk(rd, 32'h93);
    chk(n_start, 8'h01);
    wait_idle();
    chk(rd, 32'h13);
    chk(conversion_busy, 1'b0);
    $display("test start done");
    wr(CCZ_OFFSET, 32'h80, 4'h1, RESP_OKAY);
    chk(n_start, 8'h01);
    dly = 8'hc8;
    wr(CCZ_OFFSET, 32'h90, 4'h1, RESP_OKAY);
    wr(CCZ_OFFSET, 32'h00, 4'h1, RESP_OKAY);
    rdr(CCZ_OFFSET, RESP_OKAY);
    chk(rd, 32'h00);
    chk(n_start, 8'h02);
    $display("test power done");
    wr(12'hf74, 32'h37, 4'h1, RESP_DECERR);
    rdr(12'hf74, RESP_DECERR);
    chk(rd, 32'h0);
    wr(CCZ_OFFSET, 32'h37, 4'h0, RESP_OKAY);
    rdr(CCZ_OFFSET, RESP_OKAY);
    chk(rd, 32'h0);
    $display("test decode done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
